// >>> core/acfg_pkg.sv
package acfg_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int unsigned REG_ADDR_W = 6;
    localparam logic [5:0]  IFOPT_ADDR = 6'h02;
    localparam logic [5:0]  CFG_ADDR   = 6'h03;
    localparam logic [15:0] IFOPT_RESET = 16'h0000;
    localparam logic [15:0] CFG_RESET   = 16'h1340;
    localparam logic [15:0] IFOPT_WMASK = 16'h004d;
    localparam logic [15:0] CFG_WMASK   = 16'h1fff;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned IFOPT_SHORT_BIT  = 0;
    localparam int unsigned IFOPT_CRC_LSB    = 2;
    localparam int unsigned IFOPT_APPEND_BIT = 6;
    localparam int unsigned CFG_CODING_BIT   = 12;
    localparam int unsigned CFG_REFBUF_LSB   = 10;
    localparam int unsigned CFG_INBUF_LSB    = 8;

    // ------------------------------------------------------------
    // checksum encodings and result sizes
    // ------------------------------------------------------------
    localparam logic [1:0] CRC_OFF    = 2'h0;
    localparam logic [1:0] CRC_XOR_RD = 2'h1;
    localparam logic [1:0] CRC_BOTH   = 2'h2;
    localparam logic [1:0] CRC_RSVD   = 2'h3;
    localparam logic [1:0] CRC_EXTRA_BYTES = 2'h1;
    localparam int unsigned RES_LONG_BITS  = 24;
    localparam int unsigned RES_SHORT_BITS = 16;
    localparam int unsigned STATUS_BITS    = 8;
    localparam logic [5:0]  LEN_SHORT  = 6'h10;
    localparam logic [5:0]  LEN_LONG   = 6'h18;
    localparam logic [5:0]  LEN_STATUS = 6'h08;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wrEn;
        logic        rdEn;
        logic [5:0]  addr;
        logic [15:0] wdata;
    } acfg_reg_req_t;

    typedef struct packed {
        logic        valid;
        logic [23:0] data;
        logic [7:0]  status;
    } acfg_conv_t;

    typedef struct packed {
        logic [31:0] word;
        logic [5:0]  bits;
    } acfg_result_t;

    typedef struct packed {
        logic       crcActive;
        logic       crcOnWrite;
        logic       crcOnRead;
        logic       xorOnRead;
        logic [1:0] extraBytes;
    } acfg_link_t;

    typedef struct packed {
        logic [15:0]  ifopt;
        logic [15:0]  cfg;
        logic [15:0]  rdData;
        acfg_result_t result;
    } acfg_state_t;

endpackage : acfg_pkg

// >>> core/acfg_result_fmt.sv
`timescale 1ns/1ps
`default_nettype none
module acfg_result_fmt #(
    parameter int unsigned RESULT_W = 24,
    parameter int unsigned SHORT_W  = 16
) (
    input  wire logic [RESULT_W-1:0] rawData,
    input  wire logic                bipolar,
    output logic      [RESULT_W-1:0] codedLong,
    output logic      [SHORT_W-1:0]  codedShort
);
    import acfg_pkg::*;

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (SHORT_W >= RESULT_W || SHORT_W < 2) begin : g_bad_width
        $error("short width must be below result width");
    end

    logic [SHORT_W-1:0] upper;
    logic               roundUp;

    // ------------------------------------------------------------
    // coding and rounding
    // ------------------------------------------------------------
    always_comb begin
        if (bipolar) begin
            codedLong = rawData ^ {1'b1, {(RESULT_W-1){1'b0}}};
        end else if (rawData[RESULT_W-1]) begin
            codedLong = '0;
        end else begin
            codedLong = {rawData[RESULT_W-2:0], 1'b0};
        end
        upper   = codedLong[RESULT_W-1 -: SHORT_W];
        roundUp = codedLong[RESULT_W-SHORT_W-1] && (upper != {SHORT_W{1'b1}});
        codedShort = upper + {{(SHORT_W-1){1'b0}}, roundUp};
    end

endmodule : acfg_result_fmt
`default_nettype wire

// >>> core/acfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
module acfg_regs (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire acfg_pkg::acfg_reg_req_t regReq,
    output logic      [15:0]           regRdData,
    input  wire logic [1:0]            frontEndCrcSel,
    input  wire acfg_pkg::acfg_conv_t  conv,
    output acfg_pkg::acfg_result_t     result,
    output acfg_pkg::acfg_link_t       linkCfg,
    output logic                       outputCodingSelect,
    output logic                       refBufPos,
    output logic                       refBufNeg,
    output logic      [1:0]            inputBufferSelect,
    output logic                       shortWordSelect,
    output logic                       statusAppend
);
    import acfg_pkg::*;

    acfg_state_t q;
    acfg_state_t d;

    logic [RES_LONG_BITS-1:0]  codedLong;
    logic [RES_SHORT_BITS-1:0] codedShort;
    logic [1:0]                crcField;

    // ------------------------------------------------------------
    // result coding
    // ------------------------------------------------------------
    acfg_result_fmt #(
        .RESULT_W (RES_LONG_BITS),
        .SHORT_W  (RES_SHORT_BITS)
    ) acfg_result_fmt_inst (
        .rawData    (conv.data),
        .bipolar    (q.cfg[CFG_CODING_BIT]),
        .codedLong  (codedLong),
        .codedShort (codedShort)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        if (regReq.wrEn) begin
            if (regReq.addr == IFOPT_ADDR) begin
                d.ifopt = regReq.wdata & IFOPT_WMASK;
            end
            if (regReq.addr == CFG_ADDR) begin
                d.cfg = regReq.wdata & CFG_WMASK;
            end
        end
        if (regReq.rdEn) begin
            case (regReq.addr)
                IFOPT_ADDR: d.rdData = q.ifopt;
                CFG_ADDR:   d.rdData = q.cfg;
                default:    d.rdData = 16'h0000;
            endcase
        end
        if (conv.valid) begin
            // width taken from the setting at completion
            if (q.ifopt[IFOPT_SHORT_BIT]) begin
                if (q.ifopt[IFOPT_APPEND_BIT]) begin
                    d.result.word = {8'h00, codedShort, conv.status};
                    d.result.bits = LEN_SHORT + LEN_STATUS;
                end else begin
                    d.result.word = {16'h0000, codedShort};
                    d.result.bits = LEN_SHORT;
                end
            end else if (q.ifopt[IFOPT_APPEND_BIT]) begin
                d.result.word = {codedLong, conv.status};
                d.result.bits = LEN_LONG + LEN_STATUS;
            end else begin
                d.result.word = {8'h00, codedLong};
                d.result.bits = LEN_LONG;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q.ifopt       <= IFOPT_RESET;
            q.cfg         <= CFG_RESET;
            q.rdData      <= 16'h0000;
            q.result.word <= 32'h00000000;
            q.result.bits <= LEN_LONG;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign crcField = q.ifopt[IFOPT_CRC_LSB +: 2];

    always_comb begin
        linkCfg.crcActive  = (frontEndCrcSel != 2'h0) && (crcField != CRC_OFF)
                             && (crcField != CRC_RSVD);
        linkCfg.crcOnWrite = linkCfg.crcActive;
        linkCfg.crcOnRead  = linkCfg.crcActive && (crcField == CRC_BOTH);
        linkCfg.xorOnRead  = linkCfg.crcActive && (crcField == CRC_XOR_RD);
        linkCfg.extraBytes = linkCfg.crcActive ? CRC_EXTRA_BYTES : 2'h0;
    end

    assign regRdData          = q.rdData;
    assign result             = q.result;
    assign outputCodingSelect = q.cfg[CFG_CODING_BIT];
    assign refBufPos          = q.cfg[CFG_REFBUF_LSB+1];
    assign refBufNeg          = q.cfg[CFG_REFBUF_LSB];
    assign inputBufferSelect  = q.cfg[CFG_INBUF_LSB +: 2];
    assign shortWordSelect    = q.ifopt[IFOPT_SHORT_BIT];
    assign statusAppend       = q.ifopt[IFOPT_APPEND_BIT];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_CRC_NEEDS_BOTH: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (frontEndCrcSel == 2'h0 || crcField == CRC_OFF) |-> !linkCfg.crcActive)
        else $error("checksum active without both enables");

    AST_CRC_XOR_MODE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (frontEndCrcSel != 2'h0 && crcField == CRC_XOR_RD)
        |-> (linkCfg.xorOnRead && !linkCfg.crcOnRead && linkCfg.crcOnWrite))
        else $error("xor read mode decoded wrongly");

    AST_CRC_RSVD_OFF: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (crcField == CRC_RSVD) |-> (linkCfg == '0))
        else $error("reserved checksum code enabled protection");

    AST_EXTRA_BYTE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (regReq.wrEn && regReq.addr == IFOPT_ADDR && regReq.wdata[3:2] == CRC_BOTH
         && frontEndCrcSel != 2'h0) ##1 (frontEndCrcSel != 2'h0)
        |-> (linkCfg.extraBytes == 2'h1 && linkCfg.crcOnRead))
        else $error("checksum byte not added after enabling");

    AST_STATUS_APPEND: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (conv.valid && statusAppend)
        |=> (result.word[7:0] == $past(conv.status)))
        else $error("status byte not appended");

    AST_STATUS_PAIRED: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !conv.valid |=> $stable(result))
        else $error("result changed without a conversion");

    AST_SHORT_ROUND: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (conv.valid && shortWordSelect && !statusAppend && outputCodingSelect
         && conv.data[23:8] != 16'h7fff)
        |=> (result.bits == LEN_SHORT && result.word[31:16] == 16'h0000
             && result.word[15:0] == ({~$past(conv.data[23]), $past(conv.data[22:8])}
                                      + {15'h0000, $past(conv.data[7])})))
        else $error("short result not rounded to 16 bits");

    AST_LONG_WIDTH: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (conv.valid && !shortWordSelect && !statusAppend) |=> (result.bits == LEN_LONG))
        else $error("long result length wrong");

    AST_NO_RESTART: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (regReq.wrEn && regReq.addr == IFOPT_ADDR && !conv.valid) |=> $stable(result))
        else $error("interface write disturbed held result");

    AST_WIDTH_NEXT_RESULT: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (regReq.wrEn && regReq.addr == IFOPT_ADDR && regReq.wdata[0] && !conv.valid)
        ##1 (conv.valid && !statusAppend) |=> (result.bits == LEN_SHORT))
        else $error("first result after write not short");

    AST_BIPOLAR_CODE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (conv.valid && outputCodingSelect && !shortWordSelect && !statusAppend)
        |=> (result.word[23] == !$past(conv.data[23])
             && result.word[22:0] == $past(conv.data[22:0])))
        else $error("offset binary coding wrong");

    AST_UNIPOLAR_CLAMP: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (conv.valid && !outputCodingSelect && conv.data[23] && !shortWordSelect
         && !statusAppend) |=> (result.word == 32'h00000000))
        else $error("negative unipolar result not clamped");

    AST_REFBUF_DECODE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (regReq.wrEn && regReq.addr == CFG_ADDR)
        |=> (refBufPos == $past(regReq.wdata[11]) && refBufNeg == $past(regReq.wdata[10])))
        else $error("reference buffer field not decoded");

    AST_RESET_VALUES: assert property (
        @(posedge sys_clk)
        !rst_n |-> (q.ifopt == IFOPT_RESET && q.cfg == CFG_RESET && outputCodingSelect
                    && !refBufPos && !refBufNeg))
        else $error("reset values wrong");

    AST_APPEND_32: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (conv.valid && statusAppend && !shortWordSelect) |=> (result.bits == 6'h20))
        else $error("appended read is not 32 bits");

    AST_RESERVED_ZERO: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (regReq.rdEn && (regReq.addr == IFOPT_ADDR || regReq.addr == CFG_ADDR))
        |=> ((regRdData & ~(IFOPT_WMASK | CFG_WMASK)) == 16'h0000
             && (q.ifopt & ~IFOPT_WMASK) == 16'h0000))
        else $error("reserved bits read nonzero");

    // ------------------------------------------------------------
    // register and result checks
    // ------------------------------------------------------------
    AST_IFOPT_STORE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (regReq.wrEn && regReq.addr == IFOPT_ADDR)
        |=> (q.ifopt == ($past(regReq.wdata) & IFOPT_WMASK)))
        else $error("interface register write not stored");

    AST_CFG_STORE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (regReq.wrEn && regReq.addr == CFG_ADDR)
        |=> (q.cfg == ($past(regReq.wdata) & CFG_WMASK)))
        else $error("configuration register write not stored");

    AST_OTHER_ADDR_ZERO: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (regReq.rdEn && regReq.addr != IFOPT_ADDR && regReq.addr != CFG_ADDR)
        |=> (regRdData == 16'h0000))
        else $error("read of unmapped address not zero");

    AST_OTHER_ADDR_IGNORED: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (regReq.wrEn && regReq.addr != IFOPT_ADDR && regReq.addr != CFG_ADDR)
        |=> ($stable(q.ifopt) && $stable(q.cfg)))
        else $error("write to unmapped address changed a register");

    AST_MODE_STORE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (regReq.wrEn && regReq.addr == IFOPT_ADDR)
        |=> (statusAppend == $past(regReq.wdata[IFOPT_APPEND_BIT])
             && shortWordSelect == $past(regReq.wdata[IFOPT_SHORT_BIT])))
        else $error("append or short word bit not stored");

    AST_CODING_STORE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (regReq.wrEn && regReq.addr == CFG_ADDR)
        |=> (outputCodingSelect == $past(regReq.wdata[CFG_CODING_BIT])))
        else $error("output coding bit not stored");

    AST_CRC_BOTH_MODE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (frontEndCrcSel != 2'h0 && crcField == CRC_BOTH)
        |-> (linkCfg.crcOnRead && linkCfg.crcOnWrite && !linkCfg.xorOnRead))
        else $error("crc both ways decoded wrongly");

    AST_EXTRA_ONLY_ACTIVE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !linkCfg.crcActive |-> (linkCfg.extraBytes == 2'h0))
        else $error("extra byte added without protection");

    AST_UNIPOLAR_SHIFT: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (conv.valid && !outputCodingSelect && !conv.data[23] && !shortWordSelect
         && !statusAppend) |=> (result.word == {8'h00, $past(conv.data[22:0]), 1'b0}))
        else $error("positive unipolar result not straight binary");

    AST_LONG_APPEND_ORDER: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (conv.valid && statusAppend && !shortWordSelect && outputCodingSelect)
        |=> (result.word[31:8] == ($past(conv.data) ^ 24'h800000)))
        else $error("appended result not ahead of status byte");

    AST_SHORT_APPEND_LEN: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (conv.valid && statusAppend && shortWordSelect)
        |=> (result.bits == LEN_SHORT + LEN_STATUS && result.word[31:24] == 8'h00))
        else $error("short appended result framed wrongly");

    AST_SHORT_SATURATE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (conv.valid && shortWordSelect && !statusAppend && outputCodingSelect
         && conv.data[23:8] == 16'h7fff) |=> (result.word[15:0] == 16'hffff))
        else $error("short result wrapped instead of saturating");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    COV_CRC_ACTIVE: cover property (
        @(posedge sys_clk) disable iff (!rst_n) linkCfg.crcActive && linkCfg.crcOnRead);

    COV_SHORT_APPEND: cover property (
        @(posedge sys_clk) disable iff (!rst_n)
        conv.valid && shortWordSelect && statusAppend);

    COV_WIDTH_SWITCH: cover property (
        @(posedge sys_clk) disable iff (!rst_n)
        (regReq.wrEn && regReq.addr == IFOPT_ADDR) ##[1:8] conv.valid);

    COV_UNIPOLAR: cover property (
        @(posedge sys_clk) disable iff (!rst_n) conv.valid && !outputCodingSelect);

    COV_XOR_READ: cover property (
        @(posedge sys_clk) disable iff (!rst_n) linkCfg.xorOnRead && linkCfg.crcOnWrite);

endmodule : acfg_regs
`default_nettype wire

// >>> test/acfg_conv_src.sv
`timescale 1ns/1ps
`default_nettype none
module acfg_conv_src
    import acfg_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            rst_n,
    input  wire logic            fire,
    input  wire logic [3:0]      gap,
    input  wire logic [23:0]     rawIn,
    input  wire logic [7:0]      statusIn,
    output var  acfg_pkg::acfg_conv_t conv
);
    logic       pend;
    logic [3:0] cnt;

    // ------------------------------------------------------------
    // conversion source, prompt or slow
    // ------------------------------------------------------------
    // status with result
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv <= '0;
            pend <= 1'b0;
            cnt  <= '0;
        end else begin
            conv.valid  <= 1'b0;
            conv.data   <= ~conv.data;
            conv.status <= ~conv.status;
            if (fire) begin
                pend <= 1'b1;
                cnt  <= gap;
            end else if (pend && cnt == 4'h0) begin
                conv <= {1'b1, rawIn, statusIn};
                pend <= 1'b0;
            end else if (pend) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule : acfg_conv_src
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import acfg_pkg::*;
    logic          sys_clk = 1'b0;
    logic          rst_n = 1'b1;
    acfg_reg_req_t regReq;
    logic [15:0]   regRdData;
    logic [1:0]    frontEndCrcSel;
    acfg_conv_t    conv;
    acfg_result_t  result;
    acfg_link_t    linkCfg;
    logic          outputCodingSelect;
    logic          refBufPos;
    logic          refBufNeg;
    logic [1:0]    inputBufferSelect;
    logic          shortWordSelect;
    logic          statusAppend;
    logic          fire;
    logic [3:0]    gap;
    logic [23:0]   rawIn;
    logic [7:0]    statusIn;
    logic          act;
    int            nErrors = 0;
    int            testsRun = 0;
    logic [23:0]   tv [3] = '{24'h000100, 24'h000080, 24'h7fffff};

    always #5 sys_clk = ~sys_clk;

    acfg_regs acfg_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n), .regReq(regReq),
        .regRdData(regRdData), .frontEndCrcSel(frontEndCrcSel), .conv(conv),
        .result(result), .linkCfg(linkCfg), .outputCodingSelect(outputCodingSelect),
        .refBufPos(refBufPos), .refBufNeg(refBufNeg), .inputBufferSelect(inputBufferSelect),
        .shortWordSelect(shortWordSelect), .statusAppend(statusAppend));
    acfg_conv_src acfg_conv_src_inst (.sys_clk(sys_clk), .rst_n(rst_n), .fire(fire),
        .gap(gap), .rawIn(rawIn), .statusIn(statusIn), .conv(conv));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [37:0] e, input logic [37:0] g);
        testsRun++;
        if (g !== e) begin
            nErrors++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regReq <= {1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        regReq <= '0;
        #1;
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        regReq <= {1'b0, 1'b1, a, 16'h0};
        @(posedge sys_clk);
        regReq <= '0;
        #1;
        chk("regRdData", e, regRdData);
    endtask : rd

    task automatic cv(input logic [23:0] d, input logic [7:0] s, input logic [3:0] g);
        @(posedge sys_clk);
        fire     <= 1'b1;
        rawIn    <= d;
        statusIn <= s;
        gap      <= g;
        @(posedge sys_clk);
        fire <= 1'b0;
    endtask : cv

    task automatic waitRes(input logic [37:0] e);
        int i;
        i = 0;
        #1;
        while (i < 20 && conv.valid !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        if (i == 20) begin
            nErrors++;
            $display("wrong value conv.valid expected 1 seen %b", conv.valid);
            end_sim();
        end
        @(posedge sys_clk);
        #1;
        chk("result", e, result);
    endtask : waitRes

    function automatic logic [37:0] fmt(input logic [23:0] d, input logic [7:0] s,
                                        input logic bip, input logic sh, input logic ap);
        logic [23:0] c;
        logic [16:0] r;
        c = bip ? (d ^ 24'h800000) : (d[23] ? 24'h0 : {d[22:0], 1'b0});
        r = {1'b0, c[23:8]} + {16'h0, c[7]};
        if (r[16]) r = 17'h0ffff;
        if (sh) return ap ? {8'h0, r[15:0], s, 6'd24} : {16'h0, r[15:0], 6'd16};
        return ap ? {c, s, 6'd32} : {8'h0, c, 6'd24};
    endfunction : fmt

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        regReq = '0;
        frontEndCrcSel = 2'h0;
        fire = 1'b0;
        gap = 4'h0;
        rawIn = 24'h0;
        statusIn = 8'h0;
        #1;
        rst_n = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk("result", {32'h0, 6'd24}, result);
        chk("coding", 1, outputCodingSelect);
        chk("refbuf", 0, {refBufPos, refBufNeg});
        chk("inbuf", 3, inputBufferSelect);
        rd(IFOPT_ADDR, 16'h0000);
        rd(CFG_ADDR, 16'h1340);
        wr(IFOPT_ADDR, 16'hffff);
        rd(IFOPT_ADDR, 16'h004d);
        wr(CFG_ADDR, 16'hffff);
        rd(CFG_ADDR, 16'h1fff);
        wr(6'h05, 16'hffff);
        rd(6'h05, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            wr(CFG_ADDR, {4'h0, k[1:0], 10'h0});
            chk("refbuf", k[1:0], {refBufPos, refBufNeg});
            chk("coding", 0, outputCodingSelect);
        end
        for (int k = 0; k < 8; k++) begin
            wr(IFOPT_ADDR, {12'h0, k[1:0], 2'h0});
            @(posedge sys_clk);
            frontEndCrcSel <= {k[2], k[2] & k[0]};
            #1;
            act = k[2] && (k[1:0] == 2'h1 || k[1:0] == 2'h2);
            chk("crcActive", act, linkCfg.crcActive);
            chk("extraBytes", act ? 2'h1 : 2'h0, linkCfg.extraBytes);
            if (act) chk("kind", {1'b1, k[1], k[0]}, linkCfg[4:2]);
        end
        wr(IFOPT_ADDR, 16'h0000);
        cv(24'h000100, 8'h5a, 4'h0);
        waitRes(fmt(24'h000100, 8'h5a, 1'b0, 1'b0, 1'b0));
        cv(24'h800100, 8'h11, 4'h2);
        waitRes(fmt(24'h800100, 8'h11, 1'b0, 1'b0, 1'b0));
        wr(CFG_ADDR, 16'h1340);
        chk("inbuf", 3, inputBufferSelect);
        for (int m = 0; m < 4; m++) begin
            wr(IFOPT_ADDR, {9'h0, m[1], 5'h0, m[0]});
            chk("modes", m[1:0], {statusAppend, shortWordSelect});
            for (int j = 0; j < 3; j++) begin
                cv(tv[j], 8'ha0 + 8'(j), 4'(m));
                waitRes(fmt(tv[j], 8'ha0 + 8'(j), 1'b1, m[0], m[1]));
            end
        end
        cv(24'h000100, 8'h3c, 4'h0);
        wr(IFOPT_ADDR, 16'h0000);
        chk("result", fmt(24'h000100, 8'h3c, 1'b1, 1'b1, 1'b1), result);
        cv(24'h123456, 8'h07, 4'h1);
        wr(IFOPT_ADDR, 16'h0001);
        chk("result", fmt(24'h000100, 8'h3c, 1'b1, 1'b1, 1'b1), result);
        waitRes(fmt(24'h123456, 8'h07, 1'b1, 1'b1, 1'b0));
        end_sim();
    end
endmodule : tb
`default_nettype wire
